// ==== src/pdm_ctrl.sv ====
// power-down mode controller with wishbone register slave
`timescale 1ns/100ps
`default_nettype none
`include "pdm_regs.svh"
module pdm_ctrl
  import pdm_pkg::*;
#(
  parameter int IRQ_W = 12
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output var  logic [31:0]      wb_dat_o,
  output var  logic             wb_ack_o,
  // interrupt logic
  input  wire logic [IRQ_W-1:0] irq_i,
  output var  logic             resume_o,
  output var  logic             service_o,
  // clock generator
  input  wire logic             clkgen_lock_i,
  output var  logic             cpu_clk_en_o,
  output var  logic             clkgen_out_en_o,
  output var  logic             main_ref_clk_en_o,
  output var  logic             io_hold_o,
  // emulator
  input  wire logic             emu_attach_i,
  input  wire logic             emu_rst_i,
  input  wire logic             emu_step_i,
  input  wire logic             emu_pc_wr_i,
  output var  logic             emu_spin_o,
  output var  logic             emu_pc_wr_fail_o,
  // configuration pins and peripheral enables
  input  wire logic             local_bus_pin_i,
  input  wire logic             host_port_width_pin_i,
  input  wire logic             network_select_pin_i,
  output var  logic             host_port_en_o,
  output var  logic             host_port_wide_o,
  output var  logic             local_bus_en_o,
  output var  logic             network_en_o,
  output var  logic [6:0]       periph_en_o
);

  typedef struct packed {
    pdm_mode_type     st;
    logic [5:0]       fld;
    logic             global_irq_enable;
    logic             nonmaskable_irq_enable;
    logic [IRQ_W-1:0] ien;
    logic [6:0]       pcfg;
    logic [3:0]       cnt;
    logic             any_wake;
    logic             emu_mask;
    logic             attach_q;
    logic             lb_sel;
    logic             hp_wide;
    logic             net_sel;
    logic             hp_en;
    logic             ack;
    logic [31:0]      rdat;
    logic             cpu_en;
    logic             out_en;
    logic             ref_en;
    logic             hold;
    logic             resume;
    logic             service;
    logic             spin;
    logic             pc_fail;
  } pdm_state_type;

  pdm_state_type s;
  pdm_state_type n;

  logic [5:0]  pin_s;
  logic        lock_s;
  logic        attach_s;
  logic        emu_rst_s;
  logic        bus_req;
  logic        wr_csr;
  logic        en_hit;
  logic [31:0] csr_word;
  logic [31:0] ier_word;
  logic [31:0] stat_word;

  // wake test for the cpu halt: enabled lines only, or any line
  function automatic logic wake_hit(
    input logic             any,
    input logic [IRQ_W-1:0] irq,
    input logic [IRQ_W-1:0] ien
  );
    wake_hit = any ? (|irq) : (|(irq & ien));
  endfunction

  // pins from outside the domain, including reset-time straps
  pdm_sync #(
    .W (6)
  ) u_sync (
    .clk_i (clk_i),
    .d_i   ({clkgen_lock_i, emu_attach_i, emu_rst_i,
             local_bus_pin_i, host_port_width_pin_i, network_select_pin_i}),
    .q_o   (pin_s)
  );

  assign lock_s    = pin_s[5];
  assign attach_s  = pin_s[4];
  assign emu_rst_s = pin_s[3];

  // bus decode; a request is served once, in the cycle before ack
  assign bus_req = wb_cyc_i && wb_stb_i && !s.ack;
  assign wr_csr  = bus_req && wb_we_i && wb_sel_i[1] && (wb_adr_i == `PDM_ADR_CSR);
  assign en_hit  = |(irq_i & s.ien);

  // read views of the registers; unused bits read zero
  always_comb
  begin
    csr_word = 32'h0000_0000;
    csr_word[`PDM_FLD_HI:`PDM_FLD_LO] = s.fld;
    csr_word[`PDM_GIE_BIT] = s.global_irq_enable;
    ier_word = 32'h0000_0000;
    ier_word[`PDM_NONMASKABLE_IRQ_ENABLE_BIT] = s.nonmaskable_irq_enable;
    ier_word[`PDM_IEN_LO +: IRQ_W] = s.ien;
    stat_word = {21'h00000, s.lb_sel, s.hp_wide, s.net_sel, s.emu_mask, 1'b0, s.st};
  end

  // next state of the whole controller
  always_comb
  begin
    n         = s;
    n.ack     = 1'b0;
    n.resume  = 1'b0;
    n.service = 1'b0;
    n.spin    = 1'b0;
    n.pc_fail = 1'b0;

    // emulator masking: armed by attach, dropped by emulator reset or removal
    if (emu_rst_s || !attach_s)
    begin
      n.emu_mask = 1'b0;
    end
    else if (!s.attach_q)
    begin
      n.emu_mask = 1'b1;
    end
    n.attach_q = attach_s;

    // mode sequencing
    unique case (s.st)
      ST_RUN:
      begin
        n.st = ST_RUN;
      end
      ST_ARM:
      begin
        if (s.cnt != 4'h0)
        begin
          n.cnt = s.cnt - 4'h1;
        end
        else if (s.emu_mask)
        begin
          n.st = ST_RUN;
        end
        else
        begin
          // decode the field once the delay has run out
          case (s.fld)
            `PDM_CODE_H1EN:
            begin
              n.st       = ST_HALT1;
              n.any_wake = 1'b0;
            end
            `PDM_CODE_H1ANY:
            begin
              n.st       = ST_HALT1;
              n.any_wake = 1'b1;
            end
            `PDM_CODE_OHALT:
            begin
              n.st = ST_OHALT;
            end
            `PDM_CODE_IHALT:
            begin
              n.st = ST_IHALT;
            end
            default:
            begin
              n.st = ST_RUN; // normal code and reserved codes
            end
          endcase
        end
      end
      ST_HALT1:
      begin
        // the emulator must regain the cpu, so masking also ends the halt
        if (s.emu_mask || wake_hit(s.any_wake, irq_i, s.ien))
        begin
          n.st      = ST_RUN;
          n.resume  = 1'b1;
          n.service = en_hit && s.global_irq_enable && s.nonmaskable_irq_enable;
        end
      end
      ST_OHALT, ST_IHALT:
      begin
        // interrupts are ignored here; only rst_i leaves
        n.spin    = emu_step_i;
        n.pc_fail = emu_pc_wr_i;
      end
      ST_LOCK:
      begin
        // cpu held after reset until the clock generator has relocked
        if (lock_s)
        begin
          n.st = ST_RUN;
        end
      end
    endcase

    // wishbone read: registered data with the ack
    if (bus_req)
    begin
      n.ack = 1'b1;
      case (wb_adr_i)
        `PDM_ADR_CSR:  n.rdat = csr_word;
        `PDM_ADR_IER:  n.rdat = ier_word;
        `PDM_ADR_PCFG: n.rdat = {25'h000000, s.pcfg};
        `PDM_ADR_STAT: n.rdat = stat_word;
        default:       n.rdat = 32'h0000_0000;
      endcase
    end

    // wishbone write; unmapped writes are acked and dropped
    if (bus_req && wb_we_i)
    begin
      case (wb_adr_i)
        `PDM_ADR_CSR:
        begin
          if (wb_sel_i[0])
          begin
            n.global_irq_enable = wb_dat_i[`PDM_GIE_BIT];
          end
          if (wb_sel_i[1])
          begin
            // the whole field lands in one byte lane
            n.fld = wb_dat_i[`PDM_FLD_HI:`PDM_FLD_LO];
            // a new code restarts the delay; halted states ignore it
            if (s.st == ST_RUN || s.st == ST_ARM)
            begin
              n.st  = ST_ARM;
              n.cnt = `PDM_ARM_CYC - 4'h1;
            end
          end
        end
        `PDM_ADR_IER:
        begin
          if (wb_sel_i[0])
          begin
            n.nonmaskable_irq_enable = wb_dat_i[`PDM_NONMASKABLE_IRQ_ENABLE_BIT];
          end
          if (wb_sel_i[1])
          begin
            n.ien = wb_dat_i[`PDM_IEN_LO +: IRQ_W];
          end
        end
        `PDM_ADR_PCFG:
        begin
          if (wb_sel_i[0])
          begin
            n.pcfg = wb_dat_i[6:0];
          end
        end
        default:
        begin
          n.pcfg = s.pcfg;
        end
      endcase
    end

    // clock gates follow the next state so they leave the flops with it
    n.cpu_en = (n.st == ST_RUN) || (n.st == ST_ARM);
    n.out_en = (n.st != ST_OHALT) && (n.st != ST_IHALT);
    n.ref_en = (n.st != ST_IHALT); // no other input clock is gated
    n.hold   = !n.out_en;

    // synchronous reset; straps are caught while reset is held
    if (rst_i)
    begin
      n          = '0;
      n.st       = ST_LOCK;
      n.fld      = `PDM_FLD_RST;
      n.pcfg     = `PDM_PCFG_RST;
      n.out_en   = 1'b1;
      n.ref_en   = 1'b1;
      n.attach_q = attach_s;
      n.lb_sel   = pin_s[2];
      n.hp_wide  = pin_s[1];
      n.net_sel  = pin_s[0];
      // host port enable kept in its own flop so the output has no gate after it
      n.hp_en    = !pin_s[2];
    end
  end

  // the only register process
  always_ff @(posedge clk_i)
  begin
    s <= n;
  end

  // outputs straight from the state flops
  assign wb_dat_o          = s.rdat;
  assign wb_ack_o          = s.ack;
  assign resume_o          = s.resume;
  assign service_o         = s.service;
  assign cpu_clk_en_o      = s.cpu_en;
  assign clkgen_out_en_o   = s.out_en;
  assign main_ref_clk_en_o = s.ref_en;
  assign io_hold_o         = s.hold;
  assign emu_spin_o        = s.spin;
  assign emu_pc_wr_fail_o  = s.pc_fail;
  assign host_port_en_o    = s.hp_en;
  assign host_port_wide_o  = s.hp_wide;
  assign local_bus_en_o    = s.lb_sel;
  assign network_en_o      = s.net_sel;
  assign periph_en_o       = s.pcfg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // cpu keeps running through the whole delay, then stops
  sequence q_arm_step;
    cpu_clk_en_o && !wr_csr && !s.emu_mask;
  endsequence

  // nine steps as eight plus one keeps the unrolled repetition small
  sequence q_arm_run;
    q_arm_step [*8] ##1 q_arm_step;
  endsequence

  property p_arm_delay;
    wr_csr && (wb_dat_i[`PDM_FLD_HI:`PDM_FLD_LO] == `PDM_CODE_H1EN)
      && (s.st == ST_RUN) && !s.emu_mask
      |=> q_arm_run ##1 !cpu_clk_en_o;
  endproperty
  a_arm_delay: assert property (p_arm_delay)
    else $error("halt did not follow the field write after nine cycles");

  property p_halt1_wake;
    (s.st == ST_HALT1) && en_hit |=> resume_o && cpu_clk_en_o;
  endproperty
  a_halt1_wake: assert property (p_halt1_wake)
    else $error("enabled interrupt did not wake the cpu halt");

  property p_halt1_sleep;
    (s.st == ST_HALT1) && !s.any_wake && !en_hit && !s.emu_mask
      |=> !resume_o && !cpu_clk_en_o;
  endproperty
  a_halt1_sleep: assert property (p_halt1_sleep)
    else $error("cpu halt left without an enabled interrupt");

  property p_any_wake;
    (s.st == ST_HALT1) && s.any_wake && (|irq_i) && !en_hit
      |=> resume_o && !service_o;
  endproperty
  a_any_wake: assert property (p_any_wake)
    else $error("non-enabled wake ran a service routine or failed");

  property p_service;
    (s.st == ST_HALT1) && en_hit |=> service_o == $past(s.global_irq_enable && s.nonmaskable_irq_enable);
  endproperty
  a_service: assert property (p_service)
    else $error("service request does not match the enable bits");

  sequence q_frozen;
    io_hold_o && !clkgen_out_en_o && !cpu_clk_en_o;
  endsequence

  property p_clkgen_halt;
    ((s.st == ST_OHALT) || (s.st == ST_IHALT)) |=> q_frozen [*2];
  endproperty
  a_clkgen_halt: assert property (p_clkgen_halt)
    else $error("clock generator halt ended without reset");

  property p_ref_gate;
    (s.st == ST_IHALT) |=> !main_ref_clk_en_o ##1 !main_ref_clk_en_o;
  endproperty
  a_ref_gate: assert property (p_ref_gate)
    else $error("reference clock still enabled in input halt");

  property p_pc_fail;
    (s.st == ST_OHALT) && emu_pc_wr_i |=> emu_pc_wr_fail_o ##1 (s.st == ST_OHALT);
  endproperty
  a_pc_fail: assert property (p_pc_fail)
    else $error("program counter write not refused in halt");

  property p_mask;
    s.emu_mask && (s.st == ST_ARM) && attach_s && !emu_rst_s |=> cpu_clk_en_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("power-down entered while the emulator is attached");

  property p_lock;
    (s.st == ST_LOCK) && !lock_s |=> !cpu_clk_en_o;
  endproperty
  a_lock: assert property (p_lock)
    else $error("cpu released before the clock generator locked");

endmodule
`default_nettype wire

// ==== src/pdm_pkg.sv ====
// types shared by the power-down controller
`include "pdm_regs.svh"
package pdm_pkg;

  // controller states, one-hot
  typedef enum logic [5:0] {
    ST_RUN   = 6'h01,
    ST_ARM   = 6'h02,
    ST_HALT1 = 6'h04,
    ST_OHALT = 6'h08,
    ST_IHALT = 6'h10,
    ST_LOCK  = 6'h20
  } pdm_mode_type;

endpackage

// ==== src/pdm_regs.svh ====
// register offsets, field positions, codes and counts of the power-down controller
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH

// register byte offsets on the wishbone slave
`define PDM_ADR_CSR    8'h00
`define PDM_ADR_IER    8'h04
`define PDM_ADR_PCFG   8'h08
`define PDM_ADR_STAT   8'h0c

// field positions
`define PDM_FLD_HI     15
`define PDM_FLD_LO     10
`define PDM_GIE_BIT    0
`define PDM_NONMASKABLE_IRQ_ENABLE_BIT   1
`define PDM_IEN_LO     4

// sleep select codes
`define PDM_CODE_NORM  6'h00
`define PDM_CODE_H1EN  6'h09
`define PDM_CODE_H1ANY 6'h11
`define PDM_CODE_OHALT 6'h1a
`define PDM_CODE_IHALT 6'h1c

// reset values
`define PDM_FLD_RST    6'h00
`define PDM_PCFG_RST   7'h00

// cycles from the field write until the mode takes effect
`define PDM_ARM_CYC    4'h9

`endif

// ==== src/pdm_sync.sv ====
// three-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pdm_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk_i,
  // asynchronous pins in, filtered levels out
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pdm_sync_type;

  pdm_sync_type s;
  pdm_sync_type n;

  // no reset: the chain carries pin levels, and reset-time straps must pass it
  always_comb
  begin
    n    = s;
    n.s1 = d_i;
    n.s2 = s.s1;
    n.s3 = s.s2;
    // a change counts only once the second and third stages agree
    n.q  = (s.s2 & s.s3) | (s.q & (s.s2 | s.s3));
  end

  always_ff @(posedge clk_i)
  begin
    s <= n;
  end

  assign q_o = s.q;

endmodule
`default_nettype wire

// ==== tb/pdm_clkgen_model.sv ====
// clock generator model: loses lock while its reference is gated, relocks after a delay
`timescale 1ns/100ps
`default_nettype none
module pdm_clkgen_model #(
  parameter int RELOCK_CYC = 60
) (
  // clock
  input  wire logic clk_i,
  // reference gate from the controller, lock back to it
  input  wire logic main_ref_clk_en_i,
  output var  logic clkgen_lock_o
);
  int cnt = 0;

  // relock counts from zero each time the reference comes back, as after power-up
  always @(posedge clk_i)
  begin
    if (main_ref_clk_en_i !== 1'b1)
    begin
      cnt <= 0;
      clkgen_lock_o <= 1'b0;
    end
    else if (cnt < RELOCK_CYC)
    begin
      cnt <= cnt + 1;
      clkgen_lock_o <= 1'b0;
    end
    else
      clkgen_lock_o <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the power-down controller
`timescale 1ns/100ps
`default_nettype none
`include "pdm_regs.svh"
module tb_top;
  localparam int          IRQ_W = 12;
  localparam int          RELOCK = 60;
  localparam logic [7:0]  A_CSR = `PDM_ADR_CSR;
  localparam logic [7:0]  A_IER = `PDM_ADR_IER;
  localparam logic [7:0]  A_CFG = `PDM_ADR_PCFG;
  localparam logic [7:0]  A_STA = `PDM_ADR_STAT;
  // straps: no local bus, wide host port, network on
  localparam logic [31:0] STRAP = 32'h00000300;

  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [3:0]       sel = 4'h0;
  logic [31:0]      wdat = 32'h0, rdat, rd;
  logic             ack, resume, service, lock, cpu_en, out_en, ref_en, hold, spin, fail;
  logic [IRQ_W-1:0] irq = '0;
  logic             attach = 1'b0, erst = 1'b0, step = 1'b0, pcwr = 1'b0;
  logic             lb_pin = 1'b0, wid_pin = 1'b1, net_pin = 1'b1;
  logic             hp_en, hp_wide, lb_en, net_en;
  logic [6:0]       pen;
  logic [1:0]       rs;
  int               err_total = 0, samples_checked = 0, cycles = 0, t, t1, t2;

  pdm_ctrl #(.IRQ_W(IRQ_W)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_i(irq), .resume_o(resume), .service_o(service), .clkgen_lock_i(lock),
    .cpu_clk_en_o(cpu_en), .clkgen_out_en_o(out_en), .main_ref_clk_en_o(ref_en),
    .io_hold_o(hold), .emu_attach_i(attach), .emu_rst_i(erst), .emu_step_i(step),
    .emu_pc_wr_i(pcwr), .emu_spin_o(spin), .emu_pc_wr_fail_o(fail),
    .local_bus_pin_i(lb_pin), .host_port_width_pin_i(wid_pin),
    .network_select_pin_i(net_pin), .host_port_en_o(hp_en), .host_port_wide_o(hp_wide),
    .local_bus_en_o(lb_en), .network_en_o(net_en), .periph_en_o(pen));

  pdm_clkgen_model #(.RELOCK_CYC(RELOCK)) clkgen (
    .clk_i(clk_i), .main_ref_clk_en_i(ref_en), .clkgen_lock_o(lock));

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // cut a hang short; the full run needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one classic wishbone cycle; request held until ack is sampled high
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask

  // reset for 8 cycles, then count cycles until the cpu clock runs again
  task automatic do_reset(output int n);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (cpu_en !== 1'b1);
  endtask

  // write the field and count cycles from ack until the cpu clock stops
  task automatic arm(input logic [31:0] v, output int n);
    wr(A_CSR, v);
    n = 0;
    while (cpu_en === 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // raise interrupt lines and report {resume seen, service with it}
  task automatic wake(input logic [IRQ_W-1:0] v, output logic [1:0] r);
    @(posedge clk_i);
    irq <= v;
    r = 2'b00;
    repeat (6)
    begin
      @(posedge clk_i);
      if (resume === 1'b1)
        r = {1'b1, service};
    end
    irq <= '0;
  endtask

  // one step and one pc write together, reply sampled a cycle later
  task automatic emu_cmd(output logic [1:0] r);
    @(posedge clk_i);
    step <= 1'b1;
    pcwr <= 1'b1;
    @(posedge clk_i);
    step <= 1'b0;
    pcwr <= 1'b0;
    @(posedge clk_i);
    r = {spin, fail};
  endtask

  initial
  begin
    do_reset(t);
    rdchk(A_CSR, 32'h0);
    rdchk(A_IER, 32'h0);
    rdchk(A_CFG, 32'h0);
    rdchk(A_STA, STRAP | 32'h1);
    chk(32'({hp_en, hp_wide, lb_en, net_en}), 32'hd, "strap enables");
    wr(A_CFG, 32'h55);
    chk(32'(pen), 32'h55, "peripheral enables");
    wr(8'h10, 32'hffff);
    rdchk(8'h10, 32'h0);
    emu_cmd(rs);
    chk(32'(rs), 32'h0, "emulator reply in run");
    $display("test reset and config done");

    wr(A_IER, 32'h12);
    rdchk(A_IER, 32'h12);
    arm(32'h2401, t);
    chk(32'(t), 32'h9, "entry delay");
    wake(12'h002, rs);
    chk(32'({rs, cpu_en}), 32'h0, "non-enabled wake");
    wake(12'h001, rs);
    chk(32'({rs, cpu_en}), 32'h7, "enabled wake");
    arm(32'h4400, t);
    chk(32'(t), 32'h9, "entry delay any");
    wake(12'h800, rs);
    chk(32'({rs, cpu_en}), 32'h5, "any wake");
    arm(32'h2400, t);
    wake(12'h001, rs);
    chk(32'(rs), 32'h2, "wake without global enable");
    wr(A_CSR, 32'h1400);
    repeat (12) @(posedge clk_i);
    rdchk(A_STA, STRAP | 32'h1);
    $display("test cpu halt done");

    arm(32'h6800, t);
    chk(32'(t), 32'h9, "output halt delay");
    chk(32'({out_en, ref_en, hold}), 32'h3, "output halt gates");
    wake(12'hfff, rs);
    chk(32'({rs, cpu_en}), 32'h0, "irq in output halt");
    emu_cmd(rs);
    chk(32'(rs), 32'h3, "emulator in output halt");
    do_reset(t1);
    rdchk(A_CSR, 32'h0);
    arm(32'h7000, t);
    chk(32'({out_en, ref_en, hold}), 32'h1, "input halt gates");
    do_reset(t2);
    chk(32'(t2 > t1 + 20), 32'h1, "relock wait");
    $display("test clock generator halts done");

    arm(32'h2400, t);
    attach <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(cpu_en), 32'h1, "emulator ends halt");
    rdchk(A_STA, STRAP | 32'h81);
    wr(A_CSR, 32'h2400);
    repeat (12) @(posedge clk_i);
    chk(32'(cpu_en), 32'h1, "masked entry");
    wr(A_CSR, 32'h0);
    erst <= 1'b1;
    repeat (6) @(posedge clk_i);
    erst <= 1'b0;
    attach <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdchk(A_STA, STRAP | 32'h1);
    $display("test emulator mask done");
    finish_test();
  end
endmodule
`default_nettype wire
